// File: pkg/modem_cmd_map.vh
`ifndef MODEM_CMD_MAP_VH
`define MODEM_CMD_MAP_VH
// host port register selects (two address inputs)
`define SEL_DATA 2'h0
`define SEL_CMD 2'h1
`define SEL_CTRL 2'h2
`define SEL_MODE 2'h3
// command byte fields
`define CMD_BIT_CLOCK_ACQ 7
`define CMD_LEVEL_ACQ 6
`define CMD_EOP_EN 5
`define CMD_ENV_EN 4
// task codes
`define TASK_NULL 4'h0
`define TASK_HEAD 4'h1
`define TASK_R3 4'h2
`define TASK_BLOCK 4'h3
`define TASK_SYNC 4'h4
`define TASK_BYTE 4'h5
`define TASK_LOAD 4'h6
`define TASK_RESET 4'h7
`define TASK_HEADZ 4'h9
`define TASK_SHORT 4'hb
`define TASK_SYNCZ 4'hc
`define TASK_PS_BIAS 4'he
`define TASK_PS_OSC 4'hf
// status bits
`define ST_BUFFER_FREE 7
`define ST_IRQ 6
// control register: level response setting field
`define CTRL_LEVEL_RESPONSE_SETTING_LSB 2
// mode register
`define MODE_TRANSMIT_NOT_RECEIVE_SELECT 7
`define MODE_IRQ_EN 6
// buffer and timing
`define BUF_DEPTH 18
`define BIT_TIME_CYC 16'h0020
`define EOP_BITS 3
`define LEV_STEP_CYC 16'h0040
`define RESET_CTRL 8'h00
`define RESET_MODE 8'h00
`endif

// File: rtl/modem_task_command_unit.v
// How it works
// - receive, level bit set, task not reset: start level acquisition
// - acquisition starts fastest, steps slower until the set response
// - level bit zero does nothing; each one-write restarts acquisition
// - transmit mode ignores level, end-packet and envelope bits
// - end-packet output high after 3 bit times at mid, drops at once
// - envelope output high while stored levels differ above 4 percent
// - status bit 0 source selected by the two detector enables
// - one enable: irq on rise; both: irq on both edges
// - quality bits 0,1 follow detectors once enabled, no irq if off
// - reset task, transmit select or power save restore quality bits
// - receive task codes decoded as listed
// - transmit task codes decoded, 2, 9 and 12 reserved
// - codes 14 and 15 select power save bias or bias and oscillator
// - transmit task other than load clears buffer free, moves buffer when room exists
// - buffer emptied: set buffer free and irq, pin low if enabled
// - receive task clears free, waits bits, decodes, then sets free
// - receive results read byte 0 first
// - 18-byte buffer at one address, auto-incrementing position
// - two address bits select write and read registers
`timescale 1ns/100ps
`include "modem_cmd_map.vh"
module modem_task_command_unit (
   input wire ref_clk, // 100 mhz clock
   input wire rstn, // synchronous reset, active low
   input wire [1:0] addr, // register select
   input wire wr_stb, // one-cycle host write strobe
   input wire rd_stb, // one-cycle host read strobe
   input wire [7:0] wr_data, // host write data
   output reg [7:0] rd_data_r, // host read data
   input wire env_raw, // envelope comparator, async
   input wire mid_raw, // signal near mid-level comparator, async
   input wire [7:0] quality_in, // measured data quality value
   input wire xfer_room, // interleave buffer has room
   input wire rx_bits_ready, // enough de-interleaved bits present
   input wire [7:0] rx_byte, // decoded receive byte
   input wire rx_byte_vld, // decoded receive byte strobe
   input wire rx_done, // receive decode finished
   output reg [7:0] tx_byte_r, // byte moved to interleave buffer
   output reg tx_byte_vld_r, // pulse with tx_byte_r
   output reg [3:0] task_r, // active task code
   output reg task_start_r, // pulse: data task started
   output reg [2:0] lev_resp_r, // level measurement response step
   output reg bit_clock_acq_r, // pulse: bit clock acquisition start
   output reg [1:0] powersave_r, // 01 bias off, 10 bias and osc off
   output reg env_out_r, // envelope detector output
   output reg eop_out_r, // end-of-packet detector output
   output reg irq_n_r // interrupt pin, active low
);
localparam ST_IDLE = 3'b001;
localparam ST_TX = 3'b010;
localparam ST_RX = 3'b100;
reg [2:0] state_r;
reg [7:0] ctrl_r;
reg [7:0] mode_r;
reg eop_en_r;
reg env_en_r;
reg dq_det_r;
reg buffer_free_r;
reg irq_r;
reg st0_r;
reg [7:0] buf_mem [0:`BUF_DEPTH-1];
reg [4:0] ptr_r;
reg [4:0] cnt_r;
reg [2:0] env_s_r;
reg [2:0] mid_s_r;
reg [15:0] mid_cnt_r;
reg [1:0] mid_bits_r;
reg lev_run_r;
reg [15:0] lev_cnt_r;
reg [7:0] dq_r;
wire tx_mode = mode_r[`MODE_TRANSMIT_NOT_RECEIVE_SELECT];
wire cmd_wr = wr_stb && (addr == `SEL_CMD);
wire [3:0] code = wr_data[3:0];
wire data_task = is_data(code, tx_mode);
wire st0_nxt;
wire edge_irq;
wire task_done;

function is_data;
   input [3:0] c;
   input tx;
   begin
      case (c)
         `TASK_HEAD, `TASK_BLOCK, `TASK_SYNC, `TASK_BYTE, `TASK_LOAD,
         `TASK_SHORT: is_data = 1'b1;
         `TASK_R3, `TASK_HEADZ, `TASK_SYNCZ: is_data = !tx;
         default: is_data = 1'b0;
      endcase
   end
endfunction

function [4:0] task_len;
   input [3:0] c;
   begin
      case (c)
         `TASK_HEAD: task_len = 5'd6;
         `TASK_BLOCK: task_len = 5'd18;
         `TASK_SYNC: task_len = 5'd4;
         `TASK_BYTE: task_len = 5'd1;
         `TASK_SHORT: task_len = 5'd4;
         default: task_len = 5'd0;
      endcase
   end
endfunction

// status bit 0 source
assign st0_nxt = (env_en_r && eop_en_r) ? (env_out_r && !eop_out_r) :
   env_en_r ? env_out_r : eop_en_r ? eop_out_r : 1'b0;
assign edge_irq = (env_en_r || eop_en_r) && !tx_mode &&
   ((st0_nxt && !st0_r) ||
   (env_en_r && eop_en_r && !st0_nxt && st0_r));
assign task_done = (state_r == ST_TX && cnt_r == 5'd0) ||
   (state_r == ST_RX && rx_done);

// detector inputs are asynchronous: three-stage sync
always @(posedge ref_clk) begin
   if (!rstn) begin
      env_s_r <= 3'h0;
      mid_s_r <= 3'h0;
   end else begin
      env_s_r <= {env_s_r[1:0], env_raw};
      mid_s_r <= {mid_s_r[1:0], mid_raw};
   end
end

// detectors
always @(posedge ref_clk) begin
   if (!rstn) begin
      env_out_r <= 1'b0;
      eop_out_r <= 1'b0;
      mid_cnt_r <= 16'h0000;
      mid_bits_r <= 2'h0;
   end else begin
      if (env_s_r[2] == env_s_r[1])
         env_out_r <= env_en_r && !tx_mode && env_s_r[1];
      if (!eop_en_r || tx_mode || (mid_s_r[2] == mid_s_r[1] &&
         !mid_s_r[1])) begin
         eop_out_r <= 1'b0;
         mid_cnt_r <= 16'h0000;
         mid_bits_r <= 2'h0;
      end else if (mid_s_r[2] == mid_s_r[1] && !eop_out_r) begin
         if (mid_cnt_r == `BIT_TIME_CYC - 16'h0001) begin
            mid_cnt_r <= 16'h0000;
            if (mid_bits_r == `EOP_BITS - 1)
               eop_out_r <= 1'b1;
            else
               mid_bits_r <= mid_bits_r + 2'h1;
         end else begin
            mid_cnt_r <= mid_cnt_r + 16'h0001;
         end
      end
   end
end

// level acquisition sequencer
always @(posedge ref_clk) begin
   if (!rstn) begin
      lev_run_r <= 1'b0;
      lev_cnt_r <= 16'h0000;
      lev_resp_r <= 3'h0;
      bit_clock_acq_r <= 1'b0;
   end else begin
      bit_clock_acq_r <= cmd_wr && !tx_mode &&
         wr_data[`CMD_BIT_CLOCK_ACQ] && code != `TASK_RESET;
      if (cmd_wr && !tx_mode && wr_data[`CMD_LEVEL_ACQ] &&
         code != `TASK_RESET) begin
         lev_run_r <= 1'b1;
         lev_resp_r <= 3'h0;
         lev_cnt_r <= 16'h0000;
      end else if (!lev_run_r) begin
         lev_resp_r <= ctrl_r[`CTRL_LEVEL_RESPONSE_SETTING_LSB +: 3];
      end else if (lev_cnt_r == `LEV_STEP_CYC - 16'h0001) begin
         lev_cnt_r <= 16'h0000;
         if (lev_resp_r >= ctrl_r[`CTRL_LEVEL_RESPONSE_SETTING_LSB +: 3])
            lev_run_r <= 1'b0;
         else
            lev_resp_r <= lev_resp_r + 3'h1;
      end else begin
         lev_cnt_r <= lev_cnt_r + 16'h0001;
      end
   end
end

// command, task handshake, buffer
always @(posedge ref_clk) begin
   if (!rstn) begin
      state_r <= ST_IDLE;
      ctrl_r <= `RESET_CTRL;
      mode_r <= `RESET_MODE;
      eop_en_r <= 1'b0;
      env_en_r <= 1'b0;
      dq_det_r <= 1'b0;
      buffer_free_r <= 1'b1;
      irq_r <= 1'b0;
      st0_r <= 1'b0;
      ptr_r <= 5'h0;
      cnt_r <= 5'h0;
      task_r <= `TASK_NULL;
      task_start_r <= 1'b0;
      powersave_r <= 2'h0;
      tx_byte_r <= 8'h00;
      tx_byte_vld_r <= 1'b0;
   end else begin
      task_start_r <= 1'b0;
      tx_byte_vld_r <= 1'b0;
      st0_r <= st0_nxt;
      if (edge_irq || task_done)
         irq_r <= 1'b1;
      else if (rd_stb && addr == `SEL_CMD)
         irq_r <= 1'b0;
      if (wr_stb && addr == `SEL_CTRL)
         ctrl_r <= wr_data;
      if (wr_stb && addr == `SEL_MODE) begin
         mode_r <= wr_data;
         if (wr_data[`MODE_TRANSMIT_NOT_RECEIVE_SELECT])
            dq_det_r <= 1'b0;
      end
      if (wr_stb && addr == `SEL_DATA && ptr_r < `BUF_DEPTH) begin
         buf_mem[ptr_r] <= wr_data;
         ptr_r <= ptr_r + 5'h1;
      end
      if (rd_stb && addr == `SEL_DATA && ptr_r < `BUF_DEPTH)
         ptr_r <= ptr_r + 5'h1;
      case (state_r)
         ST_TX: begin
            if (cnt_r == 5'd0) begin
               buffer_free_r <= 1'b1;
               ptr_r <= 5'h0;
               state_r <= ST_IDLE;
            end else if (xfer_room) begin
               tx_byte_r <= buf_mem[ptr_r];
               tx_byte_vld_r <= 1'b1;
               ptr_r <= ptr_r + 5'h1;
               cnt_r <= cnt_r - 5'h1;
            end
         end
         ST_RX: begin
            if (rx_bits_ready && rx_byte_vld && ptr_r < `BUF_DEPTH) begin
               buf_mem[ptr_r] <= rx_byte;
               ptr_r <= ptr_r + 5'h1;
            end
            if (rx_done) begin
               buffer_free_r <= 1'b1;
               ptr_r <= 5'h0;
               state_r <= ST_IDLE;
            end
         end
         default: begin
         end
      endcase
      if (cmd_wr) begin
         if (!tx_mode) begin
            eop_en_r <= wr_data[`CMD_EOP_EN];
            env_en_r <= wr_data[`CMD_ENV_EN];
            if (wr_data[`CMD_EOP_EN] || wr_data[`CMD_ENV_EN])
               dq_det_r <= 1'b1;
         end
         if (code == `TASK_RESET) begin
            state_r <= ST_IDLE;
            buffer_free_r <= 1'b1;
            ptr_r <= 5'h0;
            dq_det_r <= 1'b0;
            powersave_r <= 2'h0;
         end else if (code == `TASK_PS_BIAS ||
            code == `TASK_PS_OSC) begin
            powersave_r <= (code == `TASK_PS_OSC) ? 2'h2 : 2'h1;
            dq_det_r <= 1'b0;
         end else if (data_task && tx_mode && code == `TASK_LOAD) begin
            // scrambler output runs free: buffer and status untouched
            task_r <= code;
            task_start_r <= 1'b1;
         end else if (data_task) begin
            task_r <= code;
            task_start_r <= 1'b1;
            buffer_free_r <= 1'b0;
            ptr_r <= 5'h0;
            powersave_r <= 2'h0;
            if (tx_mode && code != `TASK_LOAD) begin
               state_r <= ST_TX;
               cnt_r <= task_len(code);
            end else begin
               state_r <= ST_RX;
            end
         end
      end
   end
end

// read mux and interrupt pin
always @(posedge ref_clk) begin
   if (!rstn) begin
      rd_data_r <= 8'h00;
      irq_n_r <= 1'b1;
      dq_r <= 8'h00;
   end else begin
      dq_r <= dq_det_r ? {quality_in[7:2], eop_out_r, env_out_r}
         : quality_in;
      irq_n_r <= !(irq_r && mode_r[`MODE_IRQ_EN]);
      if (addr == `SEL_DATA)
         rd_data_r <= (ptr_r < `BUF_DEPTH) ? buf_mem[ptr_r] : 8'h00;
      else if (addr == `SEL_CMD)
         rd_data_r <= {buffer_free_r, irq_r, 5'h00, st0_r};
      else if (addr == `SEL_CTRL)
         rd_data_r <= dq_r;
      else
         rd_data_r <= 8'h00;
   end
end

endmodule // modem_task_command_unit

// File: tb/task_cmd_checker.sv
`timescale 1ns/100ps
module task_cmd_checker (
   input wire ref_clk, // clock
   input wire rstn, // sync reset, active low
   input wire [1:0] addr, // register select
   input wire wr_stb, // write strobe
   input wire [7:0] wr_data, // write data
   input wire xfer_room, // interleave room
   input wire tx_byte_vld_r, // byte moved
   input wire task_start_r, // task start pulse
   input wire [2:0] lev_resp_r, // level response step
   input wire [1:0] powersave_r, // power save state
   input wire irq_n_r // interrupt pin
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   reg tx_h;
   reg ien_h;
   wire cw = wr_stb && addr == 2'h1;
   // control writes retarget the idle response setting directly
   wire crw = wr_stb && addr == 2'h2;
   // shadow of the mode register bits
   always @(posedge ref_clk) begin
      if (!rstn) begin
         tx_h <= 1'b0;
         ien_h <= 1'b0;
      end else if (wr_stb && addr == 2'h3) begin
         tx_h <= wr_data[7];
         ien_h <= wr_data[6];
      end
   end
   a_start_one_cycle: assert property (task_start_r |=> !task_start_r)
      else $error("start pulse too long");
   a_tx_needs_room: assert property (tx_byte_vld_r |-> $past(xfer_room))
      else $error("byte moved without room");
   a_ps_code_legal: assert property (powersave_r != 2'h3)
      else $error("bad power save state");
   a_lev_restart: assert property (
      cw && wr_data[6] && wr_data[3:0] != 4'h7
      && !tx_h |=> ##[0:2] lev_resp_r == 3'h0)
      else $error("level acquisition not restarted");
   a_lev_single_step: assert property (
      $changed(lev_resp_r) && !$past(crw, 2) &&
      lev_resp_r > $past(lev_resp_r) |-> lev_resp_r == $past(lev_resp_r)
      + 3'h1)
      else $error("level step skipped");
   a_lev_step_hold: assert property (
      $changed(lev_resp_r) && !cw
      |=> $stable(lev_resp_r) [*8])
      else $error("level step too fast");
   a_tx_no_lev: assert property (tx_h && $changed(lev_resp_r)
      |-> lev_resp_r != 3'h0)
      else $error("level restart in transmit");
   a_reset_no_lev: assert property (
      cw && wr_data[3:0] == 4'h7 |=>
      !($changed(lev_resp_r) && lev_resp_r == 3'h0) [*3])
      else $error("reset task restarted levels");
   a_irq_pin_enable: assert property ($fell(irq_n_r) |-> ien_h)
      else $error("pin low while disabled");
   cover property (tx_byte_vld_r);
   cover property ($fell(irq_n_r));
   cover property (powersave_r == 2'h2);
endmodule // task_cmd_checker
bind modem_task_command_unit task_cmd_checker chk_inst (.ref_clk(ref_clk),
   .rstn(rstn), .addr(addr), .wr_stb(wr_stb), .wr_data(wr_data),
   .xfer_room(xfer_room), .tx_byte_vld_r(tx_byte_vld_r),
   .task_start_r(task_start_r), .lev_resp_r(lev_resp_r),
   .powersave_r(powersave_r), .irq_n_r(irq_n_r));

// File: tb/rx_decoder_model.sv
`timescale 1ns/100ps
module rx_decoder_model (
   input wire ref_clk, // clock
   input wire task_start, // data task started
   input wire rx_on, // receive mode
   output reg bits_ready, // enough bits buffered
   output reg [7:0] byte_out, // decoded byte
   output reg byte_vld, // byte strobe
   output reg done // task finished
);
   integer i;
   initial begin
      bits_ready = 1'b0;
      byte_out = 8'h00;
      byte_vld = 1'b0;
      done = 1'b0;
      forever begin
         @(negedge ref_clk);
         if (task_start && rx_on) begin
            repeat (8) @(negedge ref_clk);
            bits_ready = 1'b1;
            for (i = 0; i < 3; i = i + 1) begin
               byte_out = 8'ha0 + i[7:0];
               byte_vld = 1'b1;
               @(negedge ref_clk);
               byte_vld = 1'b0;
               byte_out = ~byte_out;
               @(negedge ref_clk);
            end
            done = 1'b1;
            @(negedge ref_clk);
            done = 1'b0;
            bits_ready = 1'b0;
         end
      end
   end
endmodule // rx_decoder_model

// File: tb/modem_task_command_unit_test.sv
`timescale 1ns/100ps
module modem_task_command_unit_test;
   reg ref_clk = 1'b0;
   reg rstn = 1'b0;
   reg wr_stb = 1'b0;
   reg rd_stb = 1'b0;
   reg env_raw = 1'b0;
   reg mid_raw = 1'b0;
   reg xfer_room = 1'b0;
   reg rx_on = 1'b0;
   reg [1:0] addr = 2'h0;
   reg [7:0] wr_data = 8'h00;
   reg [7:0] quality_in = 8'h3c;
   wire rx_bits_ready, rx_byte_vld, rx_done, tx_byte_vld_r, task_start_r;
   wire bit_clock_acq_r, env_out_r, eop_out_r, irq_n_r;
   wire [7:0] rd_data_r, rx_byte, tx_byte_r;
   wire [3:0] task_r;
   wire [2:0] lev_resp_r;
   wire [1:0] powersave_r;
   integer miscompares = 0;
   integer num_checks = 0;
   integer ntx = 0;
   integer i;
   reg [7:0] txq [0:7];
   always #5 ref_clk = ~ref_clk;
   modem_task_command_unit modem_task_command_unit_inst (.ref_clk(ref_clk),
      .rstn(rstn), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .wr_data(wr_data), .rd_data_r(rd_data_r), .env_raw(env_raw),
      .mid_raw(mid_raw), .quality_in(quality_in), .xfer_room(xfer_room),
      .rx_bits_ready(rx_bits_ready), .rx_byte(rx_byte),
      .rx_byte_vld(rx_byte_vld), .rx_done(rx_done), .tx_byte_r(tx_byte_r),
      .tx_byte_vld_r(tx_byte_vld_r), .task_r(task_r),
      .task_start_r(task_start_r), .lev_resp_r(lev_resp_r),
      .bit_clock_acq_r(bit_clock_acq_r), .powersave_r(powersave_r),
      .env_out_r(env_out_r), .eop_out_r(eop_out_r), .irq_n_r(irq_n_r));
   rx_decoder_model rx_decoder_model_inst (.ref_clk(ref_clk),
      .task_start(task_start_r), .rx_on(rx_on), .bits_ready(rx_bits_ready),
      .byte_out(rx_byte), .byte_vld(rx_byte_vld), .done(rx_done));
   always @(posedge ref_clk) begin
      if (tx_byte_vld_r === 1'b1) begin
         txq[ntx[2:0]] = tx_byte_r;
         ntx = ntx + 1;
      end
   end
   task summarize;
      begin
         if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task cmp8(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task nap(input integer n);
      repeat (n) @(negedge ref_clk);
   endtask
   task wr(input [1:0] a, input [7:0] d);
      begin
         @(negedge ref_clk);
         addr = a;
         wr_data = d;
         wr_stb = 1'b1;
         @(negedge ref_clk);
         wr_stb = 1'b0;
      end
   endtask
   task rd(input [1:0] a, input [7:0] m, input [7:0] e);
      begin
         @(negedge ref_clk);
         addr = a;
         @(negedge ref_clk);
         rd_stb = 1'b1;
         @(negedge ref_clk);
         rd_stb = 1'b0;
         cmp8(rd_data_r & m, e);
      end
   endtask
   task wait_irq;
      begin
         for (i = 0; i < 2000 && irq_n_r !== 1'b0; i = i + 1)
            @(negedge ref_clk);
         cmp8({7'h0, irq_n_r}, 8'h00);
      end
   endtask
   initial begin
      #200000;
      miscompares = miscompares + 1;
      summarize;
   end
   initial begin
      nap(12);
      rstn = 1'b1;
      rd(2'h1, 8'hc0, 8'h80);
      wr(2'h3, 8'hc0);
      for (i = 0; i < 4; i = i + 1)
         wr(2'h0, 8'h10 + i[7:0]);
      wr(2'h1, 8'h74);
      nap(20);
      cmp8(ntx[7:0], 8'h00);
      rd(2'h1, 8'h80, 8'h00);
      xfer_room = 1'b1;
      wait_irq;
      cmp8(ntx[7:0], 8'h04);
      for (i = 0; i < 4; i = i + 1)
         cmp8(txq[i], 8'h10 + i[7:0]);
      rd(2'h1, 8'hc0, 8'hc0);
      nap(1);
      cmp8({7'h0, irq_n_r}, 8'h01);
      rx_on = 1'b1;
      wr(2'h3, 8'h40);
      wr(2'h2, 8'h14);
      wr(2'h1, 8'h40);
      nap(400);
      cmp8({5'h0, lev_resp_r}, 8'h05);
      wr(2'h1, 8'h47);
      nap(3);
      cmp8({5'h0, lev_resp_r}, 8'h05);
      wr(2'h1, 8'h00);
      nap(3);
      cmp8({5'h0, lev_resp_r}, 8'h05);
      wr(2'h1, 8'h40);
      nap(3);
      cmp8({5'h0, lev_resp_r}, 8'h00);
      rd(2'h1, 8'h80, 8'h80);
      wr(2'h1, 8'h01);
      rd(2'h1, 8'h80, 8'h00);
      wait_irq;
      rd(2'h1, 8'hc0, 8'hc0);
      for (i = 0; i < 3; i = i + 1)
         rd(2'h0, 8'hff, 8'ha0 + i[7:0]);
      wr(2'h0, 8'h5a);
      wr(2'h0, 8'ha5);
      wr(2'h1, 8'h06);
      wait_irq;
      rd(2'h1, 8'hc0, 8'hc0);
      wr(2'h1, 8'h10);
      env_raw = 1'b1;
      nap(10);
      cmp8({7'h0, env_out_r}, 8'h01);
      rd(2'h2, 8'h03, 8'h01);
      cmp8({7'h0, irq_n_r}, 8'h00);
      rd(2'h1, 8'h41, 8'h41);
      wr(2'h1, 8'h30);
      mid_raw = 1'b1;
      nap(120);
      cmp8({7'h0, eop_out_r}, 8'h01);
      rd(2'h1, 8'h41, 8'h40);
      mid_raw = 1'b0;
      nap(6);
      cmp8({7'h0, eop_out_r}, 8'h00);
      wr(2'h1, 8'h07);
      rd(2'h2, 8'hff, 8'h3c);
      wr(2'h1, 8'h0e);
      nap(2);
      cmp8({6'h0, powersave_r}, 8'h01);
      wr(2'h1, 8'h0f);
      nap(2);
      cmp8({6'h0, powersave_r}, 8'h02);
      summarize;
   end
endmodule // modem_task_command_unit_test
